// ### logic/tcc_map.svh
// Register indices, field positions, codes and reset values of the timer channel
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
`define TCC_ADDR_MIN   18
`define TCC_IDX_CTRL   16'hfe90
`define TCC_IDX_MODE   16'hfe91
`define TCC_IDX_IOCTRL 16'hfe92
`define TCC_IDX_INTEN  16'hfe93
`define TCC_IDX_STAT   16'hfe94
`define TCC_IDX_SYNC   16'hfe95
`define TCC_IDX_CNT    16'hfe96
`define TCC_IDX_GRA    16'hfe98
`define TCC_IDX_GRB    16'hfe9a
`define TCC_CCLR_HI    6
`define TCC_CCLR_LO    5
`define TCC_CKEG_HI    4
`define TCC_CKEG_LO    3
`define TCC_TPSC_HI    2
`define TCC_TPSC_LO    0
`define TCC_CCLR_NONE  2'b00
`define TCC_CCLR_A     2'b01
`define TCC_CCLR_B     2'b10
`define TCC_CCLR_SYNC  2'b11
`define TCC_PS_1       3'h0
`define TCC_PS_4       3'h1
`define TCC_PS_16      3'h2
`define TCC_PS_64      3'h3
`define TCC_PS_EXTA    3'h4
`define TCC_PS_EXTC    3'h5
`define TCC_PS_256     3'h6
`define TCC_PS_EXTD    3'h7
`define TCC_DIV4_BIT   1
`define TCC_DIV16_BIT  3
`define TCC_DIV64_BIT  5
`define TCC_DIV256_BIT 7
`define TCC_DIV_MIN    8
`define TCC_MODE_PHASE 2
`define TCC_MODE_MSB   3
`define TCC_IO_CAP     3
`define TCC_IO_INIT    2
`define TCC_IO_CHAIN   2
`define TCC_ST_FA      0
`define TCC_ST_FB      1
`define TCC_ST_OVF     4
`define TCC_ST_UDF     5
`define TCC_ST_MASK    8'h33
`define TCC_ADC_EN     7
`define TCC_CTRL_RST   7'h00
`define TCC_BYTE_RST   8'h00
`define TCC_GR_RST     16'hffff
`define TCC_CNT_RST    16'h0000
`define TCC_CNT_MAX    16'hffff
`endif

// ### logic/tcc_pkg.sv
// Types and helpers shared by the timer channel modules
package tcc_pkg;
    typedef logic [15:0] tcc_word_t;
    typedef enum logic [1:0] {
        TCC_BUS_IDLE = 2'b00,
        TCC_BUS_ACK  = 2'b01
    } tcc_bus_e;

    function automatic tcc_word_t tcc_merge16(input tcc_word_t old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        tcc_word_t r;
        r = old_v;
        if (be[0])
        begin
            r[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction
endpackage

// ### logic/tcc_ev_if.sv
// Count ticks, compare and capture events passed between the channel modules
`timescale 1ns/1ps
interface tcc_ev_if;
    logic       count_tick;
    logic       count_up;
    logic [2:0] prescale_sel;
    logic [1:0] edge_sel;
    logic       phase_mode;
    logic [3:0] io_code_b;
    logic       io_load;
    logic       match_b;
    logic       cap_strobe;
    modport pre (input prescale_sel, edge_sel, phase_mode,
                 output count_tick, count_up);
    modport cc  (input io_code_b, io_load, match_b, output cap_strobe);
    modport top (input count_tick, count_up, cap_strobe,
                 output prescale_sel, edge_sel, phase_mode,
                 output io_code_b, io_load, match_b);
endinterface

// ### logic/tcc_prescaler.sv
// Count source selection, edge selection and phase decoding
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_prescaler
    import tcc_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic ext_clock_pin_a,
    input  wire logic ext_clock_pin_c,
    input  wire logic ext_clock_pin_d,
    tcc_ev_if.pre     ev
);
    if (DIV_W < `TCC_DIV_MIN) $error("tcc_prescaler: DIV_W too small");

    logic [DIV_W-1:0] div_q, div_d;
    logic [2:0]       s1_q, s1_d, s2_q, s2_d, prev_q, prev_d;
    logic             src_q, src_d, tick_q, tick_d, up_q, up_d;
    logic             rise, fall, hit, chg;

    always_comb
    begin
        div_d  = div_q + {{(DIV_W-1){1'b0}}, 1'b1};
        s1_d   = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_a};
        s2_d   = s1_q;
        prev_d = s2_q;
        case (ev.prescale_sel)
            `TCC_PS_4:    src_d = div_q[`TCC_DIV4_BIT];
            `TCC_PS_16:   src_d = div_q[`TCC_DIV16_BIT];
            `TCC_PS_64:   src_d = div_q[`TCC_DIV64_BIT];
            `TCC_PS_256:  src_d = div_q[`TCC_DIV256_BIT];
            `TCC_PS_EXTA: src_d = s2_q[0];
            `TCC_PS_EXTC: src_d = s2_q[1];
            `TCC_PS_EXTD: src_d = s2_q[2];
            default:      src_d = 1'b0;
        endcase
        rise = src_d & ~src_q;
        fall = ~src_d & src_q;
        if (ev.prescale_sel == `TCC_PS_1)
        begin
            hit = 1'b1;
        end
        else if (ev.edge_sel[1])
        begin
            hit = rise | fall;
        end
        else
        begin
            hit = ev.edge_sel[0] ? fall : rise;
        end
        // Phase inputs on pins C and D; edge field has no say here
        chg = (s2_q[1] ^ prev_q[1]) | (s2_q[2] ^ prev_q[2]);
        if (ev.phase_mode)
        begin
            tick_d = chg;
            up_d   = s2_q[1] ^ prev_q[2];
        end
        else
        begin
            tick_d = hit;
            up_d   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_q  <= '0;
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            prev_q <= 3'h0;
            src_q  <= 1'b0;
            tick_q <= 1'b0;
            up_q   <= 1'b1;
        end
        else
        begin
            div_q  <= div_d;
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
            src_q  <= src_d;
            tick_q <= tick_d;
            up_q   <= up_d;
        end
    end

    assign ev.count_tick = tick_q;
    assign ev.count_up   = up_q;

    property p_fast_tick;
        @(posedge clk_sys) disable iff (reset)
        (!ev.phase_mode && ev.prescale_sel == `TCC_PS_1) |=> tick_q;
    endproperty
    a_fast_tick: assert property (p_fast_tick)
        else $error("div-1 source did not tick every cycle");
endmodule

// ### logic/tcc_capcmp.sv
// Compare pin drive and capture triggering for general register B
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_capcmp
    import tcc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin_in,
    input  wire logic neighbour_event,
    output logic      pin_out,
    output logic      pin_oe,
    tcc_ev_if.cc      ev
);
    logic       s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic       out_q, out_d, oe_q, oe_d, cap_q, cap_d;
    logic [3:0] code;
    logic       cmp_on, rise, fall;

    always_comb
    begin
        code   = ev.io_code_b;
        s1_d   = pin_in;
        s2_d   = s1_q;
        s3_d   = s2_q;
        rise   = s2_q & ~s3_q;
        fall   = ~s2_q & s3_q;
        cmp_on = !code[`TCC_IO_CAP] && code[1:0] != 2'b00;
        out_d  = out_q;
        oe_d   = oe_q;
        if (ev.io_load)
        begin
            out_d = code[`TCC_IO_INIT];
            oe_d  = cmp_on;
        end
        else if (cmp_on && ev.match_b)
        begin
            case (code[1:0])
                2'b01:   out_d = 1'b0;
                2'b10:   out_d = 1'b1;
                default: out_d = ~out_q;
            endcase
        end
        cap_d = 1'b0;
        if (code[`TCC_IO_CAP] && code[`TCC_IO_CHAIN])
        begin
            cap_d = neighbour_event;
        end
        else if (code[`TCC_IO_CAP])
        begin
            if (code[1])
            begin
                cap_d = rise | fall;
            end
            else
            begin
                cap_d = code[0] ? fall : rise;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            out_q <= 1'b0;
            oe_q  <= 1'b0;
            cap_q <= 1'b0;
        end
        else
        begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
            oe_q  <= oe_d;
            cap_q <= cap_d;
        end
    end

    assign pin_out       = out_q;
    assign pin_oe        = oe_q;
    assign ev.cap_strobe = cap_q;

    property p_init_level;
        @(posedge clk_sys) disable iff (reset)
        (ev.io_load && cmp_on) |=> (oe_q && out_q == $past(code[2]));
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("initial compare level not driven");

    property p_disabled;
        @(posedge clk_sys) disable iff (reset)
        (ev.io_load && !code[3] && code[1:0] == 2'b00) |=> !oe_q;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("compare output enabled for code with low bits clear");

    property p_toggle;
        @(posedge clk_sys) disable iff (reset)
        (!ev.io_load && !code[3] && code[1:0] == 2'b11 && ev.match_b)
            |=> out_q != $past(out_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle code did not toggle on match");

    property p_chain;
        @(posedge clk_sys) disable iff (reset)
        (code[3:2] == 2'b11 && neighbour_event) |=> cap_q;
    endproperty
    a_chain: assert property (p_chain)
        else $error("neighbour event did not trigger capture");
endmodule

// ### logic/tcc_top.sv
// Timer channel with compare and capture, Avalon-MM register slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_top
    import tcc_pkg::*;
#(
    parameter int ADDR_W = 18
)(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              ext_clock_pin_a,
    input  wire logic              ext_clock_pin_c,
    input  wire logic              ext_clock_pin_d,
    input  wire logic              capture_compare_pin_b_in,
    output logic                   capture_compare_pin_b_out,
    output logic                   capture_compare_pin_b_oe,
    input  wire logic              neighbour_event,
    input  wire logic              sync_clear_in,
    output logic                   adc_start_req,
    output logic                   irq
);
    if (ADDR_W < `TCC_ADDR_MIN) $error("tcc_top: ADDR_W too small");

    tcc_ev_if ev ();

    tcc_prescaler #(
        .DIV_W (8)
    ) u_pre (
        .clk_sys         (clk_sys),
        .reset           (reset),
        .ext_clock_pin_a (ext_clock_pin_a),
        .ext_clock_pin_c (ext_clock_pin_c),
        .ext_clock_pin_d (ext_clock_pin_d),
        .ev              (ev.pre)
    );

    tcc_capcmp u_cc (
        .clk_sys         (clk_sys),
        .reset           (reset),
        .pin_in          (capture_compare_pin_b_in),
        .neighbour_event (neighbour_event),
        .pin_out         (capture_compare_pin_b_out),
        .pin_oe          (capture_compare_pin_b_oe),
        .ev              (ev.cc)
    );

    tcc_bus_e   bus_q, bus_d;
    logic       wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    tcc_word_t  gra_q, gra_d, grb_q, grb_d, cnt_q, cnt_d;
    logic [6:0] ctrl_q, ctrl_d;
    logic [2:0] mode_q, mode_d;
    logic [7:0] io_q, io_d, inten_q, inten_d;
    logic [7:0] stat_q, stat_d, armed_q, armed_d, set_ev;
    logic       sync_q, sync_d, io_load_q, io_load_d;
    logic       eqa_q, eqa_d, eqb_q, eqb_d;
    logic       adc_q, adc_d, irq_q, irq_d;
    logic [15:0] sel;
    logic       acc, wr, rd, match_a, match_b, clr, ovf, udf;
    logic       wr_cnt, wr_grb, wr_stat;

    assign sel     = avs_address[ADDR_W-1:2];
    assign acc     = (bus_q == TCC_BUS_IDLE) && (avs_read || avs_write);
    assign wr      = acc && avs_write;
    assign rd      = acc && avs_read;
    assign wr_cnt  = wr && sel == `TCC_IDX_CNT;
    assign wr_grb  = wr && sel == `TCC_IDX_GRB;
    assign wr_stat = wr && sel == `TCC_IDX_STAT && avs_byteenable[0];

    // Match is taken on the first cycle of equality so a stalled count
    // cannot raise it again every cycle
    assign eqa_d   = cnt_q == gra_q;
    assign eqb_d   = cnt_q == grb_q;
    assign match_a = eqa_d && !eqa_q;
    assign match_b = eqb_d && !eqb_q && !io_q[7];

    assign ev.prescale_sel = ctrl_q[`TCC_TPSC_HI:`TCC_TPSC_LO];
    assign ev.edge_sel     = ctrl_q[`TCC_CKEG_HI:`TCC_CKEG_LO];
    assign ev.phase_mode   = mode_q[`TCC_MODE_PHASE];
    assign ev.io_code_b    = io_q[7:4];
    assign ev.io_load      = io_load_q;
    assign ev.match_b      = match_b;

    always_comb
    begin
        case (ctrl_q[`TCC_CCLR_HI:`TCC_CCLR_LO])
            `TCC_CCLR_A:    clr = match_a;
            `TCC_CCLR_B:    clr = match_b || ev.cap_strobe;
            `TCC_CCLR_SYNC: clr = sync_q && sync_clear_in;
            default:        clr = 1'b0;
        endcase
        ovf = ev.count_tick && ev.count_up && cnt_q == `TCC_CNT_MAX;
        udf = ev.count_tick && !ev.count_up && cnt_q == `TCC_CNT_RST;
        set_ev = 8'h00;
        set_ev[`TCC_ST_FA]  = match_a;
        set_ev[`TCC_ST_FB]  = match_b || ev.cap_strobe;
        set_ev[`TCC_ST_OVF] = ovf;
        set_ev[`TCC_ST_UDF] = udf;

        bus_d     = acc ? TCC_BUS_ACK : TCC_BUS_IDLE;
        wait_d    = !acc;
        rdata_d   = rdata_q;
        gra_d     = gra_q;
        grb_d     = grb_q;
        cnt_d     = cnt_q;
        ctrl_d    = ctrl_q;
        mode_d    = mode_q;
        io_d      = io_q;
        inten_d   = inten_q;
        sync_d    = sync_q;
        io_load_d = 1'b0;
        stat_d    = stat_q;
        armed_d   = armed_q;

        if (clr)
        begin
            cnt_d = `TCC_CNT_RST;
        end
        else if (ev.count_tick)
        begin
            cnt_d = ev.count_up ? cnt_q + 16'h0001
                                : cnt_q - 16'h0001;
        end
        if (ev.cap_strobe)
        begin
            grb_d = cnt_q;
        end

        if (rd)
        begin
            case (sel)
                `TCC_IDX_CTRL:   rdata_d = {25'h0, ctrl_q};
                `TCC_IDX_MODE:   rdata_d = {29'h0, mode_q};
                `TCC_IDX_IOCTRL: rdata_d = {24'h0, io_q};
                `TCC_IDX_INTEN:  rdata_d = {24'h0, inten_q};
                `TCC_IDX_STAT:   rdata_d = {24'h0, stat_q};
                `TCC_IDX_SYNC:   rdata_d = {31'h0, sync_q};
                `TCC_IDX_CNT:    rdata_d = {16'h0, cnt_q};
                `TCC_IDX_GRA:    rdata_d = {16'h0, gra_q};
                `TCC_IDX_GRB:    rdata_d = {16'h0, grb_q};
                default:         rdata_d = 32'h0;
            endcase
            if (sel == `TCC_IDX_STAT)
            begin
                armed_d = armed_q | stat_q;
            end
        end

        if (wr && avs_byteenable[0])
        begin
            case (sel)
                `TCC_IDX_CTRL:   ctrl_d = avs_writedata[6:0];
                `TCC_IDX_MODE:   mode_d = avs_writedata[2:0];
                `TCC_IDX_IOCTRL:
                begin
                    io_d      = avs_writedata[7:0];
                    io_load_d = 1'b1;
                end
                `TCC_IDX_INTEN:  inten_d = avs_writedata[7:0] &
                                           (`TCC_ST_MASK | 8'h80);
                `TCC_IDX_SYNC:   sync_d = avs_writedata[0];
                default:         sync_d = sync_q;
            endcase
        end
        if (wr && sel == `TCC_IDX_GRA)
        begin
            gra_d = tcc_merge16(gra_q, avs_writedata, avs_byteenable);
        end
        // Capture wins over a software write in the same cycle
        if (wr_grb && !ev.cap_strobe)
        begin
            grb_d = tcc_merge16(grb_q, avs_writedata, avs_byteenable);
        end
        if (wr_cnt)
        begin
            cnt_d = tcc_merge16(cnt_q, avs_writedata, avs_byteenable);
        end
        if (wr_stat)
        begin
            // Only zeros clear, and only flags already seen as one
            stat_d  = stat_q & ~(armed_q & ~avs_writedata[7:0]);
            armed_d = armed_q & avs_writedata[7:0];
        end
        stat_d = (stat_d | set_ev) & `TCC_ST_MASK;

        adc_d = inten_q[`TCC_ADC_EN] && match_a;
        irq_d = |(stat_q & inten_q & `TCC_ST_MASK);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bus_q     <= TCC_BUS_IDLE;
            wait_q    <= 1'b1;
            rdata_q   <= 32'h0;
            gra_q     <= `TCC_GR_RST;
            grb_q     <= `TCC_GR_RST;
            cnt_q     <= `TCC_CNT_RST;
            ctrl_q    <= `TCC_CTRL_RST;
            mode_q    <= 3'h0;
            io_q      <= `TCC_BYTE_RST;
            inten_q   <= `TCC_BYTE_RST;
            stat_q    <= `TCC_BYTE_RST;
            armed_q   <= `TCC_BYTE_RST;
            sync_q    <= 1'b0;
            io_load_q <= 1'b0;
            eqa_q     <= 1'b0;
            eqb_q     <= 1'b0;
            adc_q     <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            bus_q     <= bus_d;
            wait_q    <= wait_d;
            rdata_q   <= rdata_d;
            gra_q     <= gra_d;
            grb_q     <= grb_d;
            cnt_q     <= cnt_d;
            ctrl_q    <= ctrl_d;
            mode_q    <= mode_d;
            io_q      <= io_d;
            inten_q   <= inten_d;
            stat_q    <= stat_d;
            armed_q   <= armed_d;
            sync_q    <= sync_d;
            io_load_q <= io_load_d;
            eqa_q     <= eqa_d;
            eqb_q     <= eqb_d;
            adc_q     <= adc_d;
            irq_q     <= irq_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign adc_start_req   = adc_q;
    assign irq             = irq_q;

    property p_adc_gate;
        @(posedge clk_sys) disable iff (reset)
        adc_start_req |-> $past(inten_q[7]) && $past(match_a);
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("A/D request issued while disabled");

    property p_one_ignored;
        @(posedge clk_sys) disable iff (reset)
        (wr_stat && stat_q[0] && avs_writedata[0]) |=> stat_q[0];
    endproperty
    a_one_ignored: assert property (p_one_ignored)
        else $error("writing one cleared a flag");

    property p_flag_clear;
        @(posedge clk_sys) disable iff (reset)
        (wr_stat && armed_q[0] && !avs_writedata[0] && !match_a)
            |=> !stat_q[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag A not cleared after read and zero write");

    property p_no_blind_clear;
        @(posedge clk_sys) disable iff (reset)
        (wr_stat && !armed_q[0] && stat_q[0]) |=> stat_q[0];
    endproperty
    a_no_blind_clear: assert property (p_no_blind_clear)
        else $error("flag A cleared without a prior read");

    property p_up_only;
        @(posedge clk_sys) disable iff (reset)
        (!mode_q[2] && ev.count_tick && !clr && !wr_cnt)
            |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_up_only: assert property (p_up_only)
        else $error("counter did not count up outside phase mode");

    property p_clear_a;
        @(posedge clk_sys) disable iff (reset)
        (ctrl_q[6:5] == 2'b01 && match_a && !wr_cnt) |=> cnt_q == 16'h0000;
    endproperty
    a_clear_a: assert property (p_clear_a)
        else $error("counter not cleared on register A match");

    property p_capture;
        @(posedge clk_sys) disable iff (reset)
        ev.cap_strobe |=> grb_q == $past(cnt_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("register B did not capture the counter");

    property p_gra_rw;
        @(posedge clk_sys) disable iff (reset)
        (wr && sel == 16'hfe98 && avs_byteenable[1:0] == 2'b11)
            |=> gra_q == $past(avs_writedata[15:0]);
    endproperty
    a_gra_rw: assert property (p_gra_rw)
        else $error("register A write lost");

    property p_mode_msb;
        @(posedge clk_sys) disable iff (reset)
        (rd && sel == 16'hfe91) |=> !avs_readdata[3] ##1 avs_waitrequest;
    endproperty
    a_mode_msb: assert property (p_mode_msb)
        else $error("mode top bit read back as one");
endmodule

// ### testbench/tcc_pin_model.sv
// Far-side model: count pins, capture pin drive and neighbour channel event
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic clk_sys,
    output logic      ext_clock_pin_a,
    output logic      ext_clock_pin_c,
    output logic      ext_clock_pin_d,
    output logic      pin_drv,
    output logic      neighbour_event
);
    // Count pins rest low so an external source leaves the counter frozen
    initial {ext_clock_pin_a, ext_clock_pin_c, ext_clock_pin_d} = 3'h0;
    initial pin_drv = 1'b0;
    initial neighbour_event = 1'b0;
    // Three cycles wide: narrower pulses may be lost in the synchroniser
    task automatic pin_pulse();
        @(posedge clk_sys) pin_drv <= 1'b1;
        repeat (3) @(posedge clk_sys);
        pin_drv <= 1'b0;
    endtask
    task automatic nb_pulse();
        @(posedge clk_sys) neighbour_event <= 1'b1;
        @(posedge clk_sys) neighbour_event <= 1'b0;
    endtask
endmodule

// ### testbench/tb_timer_channel_capture_compare.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`include "tcc_map.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_timer_channel_capture_compare;
    import tcc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, rd_q = 1'b0, wr_q = 1'b0;
    logic [17:0] adr = 18'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic [3:0] be = 4'h3;
    logic wait_n, pin_o, pin_oe, pin_w, drv, nb, adc, irq, ea, ec, ed;
    logic sc = 1'b0;
    int num_errors = 0, checked = 0, cyc = 0, n;
    tcc_word_t v;
    assign pin_w = pin_oe ? pin_o : drv;
    tcc_top u_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(adr),
        .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_n),
        .ext_clock_pin_a(ea), .ext_clock_pin_c(ec), .ext_clock_pin_d(ed),
        .capture_compare_pin_b_in(pin_w), .capture_compare_pin_b_out(pin_o),
        .capture_compare_pin_b_oe(pin_oe), .neighbour_event(nb),
        .sync_clear_in(sc), .adc_start_req(adc), .irq(irq));
    tcc_pin_model u_pins (.clk_sys(clk_sys), .ext_clock_pin_a(ea),
        .ext_clock_pin_c(ec), .ext_clock_pin_d(ed), .pin_drv(drv),
        .neighbour_event(nb));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic end_sim();
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [15:0] i, input tcc_word_t d);
        @(posedge clk_sys);
        adr <= {i, 2'b00};
        rd_q <= !w;
        wr_q <= w;
        wdat <= {16'h0, d};
        do @(posedge clk_sys); while (wait_n !== 1'b0);
        r = rdat;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask
    function automatic int adc_pulses_expected(input logic en);
        return en ? 1 : 0;
    endfunction
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(48679));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        bus(0, `TCC_IDX_GRB, 0); `CHK("grb_rst", 32'hffff, r)
        bus(0, `TCC_IDX_CTRL, 0); `CHK("ctrl_rst", 32'h0, r)
        bus(0, 16'hfe80, 0); `CHK("unmapped", 32'h0, r)
        repeat (4)
        begin
            v = $urandom;
            bus(1, `TCC_IDX_GRA, v); bus(0, `TCC_IDX_GRA, 0);
            `CHK("gra", {16'h0, v}, r)
            bus(1, `TCC_IDX_GRB, ~v); bus(0, `TCC_IDX_GRB, 0);
            `CHK("grb", {16'h0, ~v}, r)
        end
        bus(1, `TCC_IDX_MODE, 16'h0f); bus(0, `TCC_IDX_MODE, 0);
        `CHK("mode_msb", 1'b0, r[`TCC_MODE_MSB])
        bus(1, `TCC_IDX_MODE, 0);
        bus(1, `TCC_IDX_IOCTRL, 16'h10); @(posedge clk_sys);
        `CHK("init_lo", 2'b10, {pin_oe, pin_o})
        bus(1, `TCC_IDX_IOCTRL, 16'h50); @(posedge clk_sys);
        `CHK("init_hi", 2'b11, {pin_oe, pin_o})
        bus(1, `TCC_IDX_IOCTRL, 16'h40); @(posedge clk_sys);
        `CHK("hi_off", 1'b0, pin_oe)
        // Counter placed below the match first so only one match toggles
        bus(1, `TCC_IDX_GRB, 16'd100); bus(1, `TCC_IDX_CNT, 16'd80);
        bus(1, `TCC_IDX_IOCTRL, 16'h30); repeat (40) @(posedge clk_sys);
        `CHK("toggle", 2'b11, {pin_oe, pin_o})
        // Frozen counter makes the captured value exact
        bus(1, `TCC_IDX_CTRL, {13'h0, `TCC_PS_EXTA}); v = $urandom;
        bus(1, `TCC_IDX_CNT, v); bus(1, `TCC_IDX_IOCTRL, 16'hc0);
        u_pins.nb_pulse(); repeat (4) @(posedge clk_sys);
        bus(0, `TCC_IDX_GRB, 0); `CHK("cap_nb", {16'h0, v}, r)
        `CHK("cap_oe", 1'b0, pin_oe)
        bus(1, `TCC_IDX_GRB, 0); bus(1, `TCC_IDX_IOCTRL, 16'h80);
        u_pins.pin_pulse(); repeat (8) @(posedge clk_sys);
        bus(0, `TCC_IDX_GRB, 0); `CHK("cap_pin", {16'h0, v}, r)
        bus(0, `TCC_IDX_STAT, 0);
        `CHK("flag_b", 1'b1, r[`TCC_ST_FB])
        bus(1, `TCC_IDX_INTEN, 16'h02); bus(1, `TCC_IDX_STAT, 16'h33);
        repeat (2) @(posedge clk_sys);
        `CHK("w1_keep", 1'b1, irq)
        bus(1, `TCC_IDX_STAT, 16'h00); repeat (2) @(posedge clk_sys);
        `CHK("w0_clear", 1'b0, irq)
        bus(1, `TCC_IDX_INTEN, 16'h00);
        // Synchronous clear only counts once the sync bit is set
        bus(1, `TCC_IDX_CTRL, {9'h0, `TCC_CCLR_SYNC, 2'b00, `TCC_PS_EXTA});
        for (int s = 0; s < 2; s++)
        begin
            bus(1, `TCC_IDX_CNT, v); bus(1, `TCC_IDX_SYNC, s[15:0]);
            @(posedge clk_sys) sc <= 1'b1;
            @(posedge clk_sys) sc <= 1'b0;
            bus(0, `TCC_IDX_CNT, 0);
            `CHK("sync_clr", (s == 1) ? 32'h0 : {16'h0, v}, r)
        end
        bus(1, `TCC_IDX_SYNC, 0);
        bus(1, `TCC_IDX_CTRL, 16'h20); bus(1, `TCC_IDX_GRA, 16'd9);
        bus(1, `TCC_IDX_CNT, 0);
        for (int e = 1; e >= 0; e--)
        begin
            bus(1, `TCC_IDX_INTEN, {8'h0, e[0], 7'h0}); n = 0;
            repeat (100) @(posedge clk_sys) n += (adc === 1'b1);
            `CHK("adc", adc_pulses_expected(e[0]), int'(n > 0))
        end
        bus(0, `TCC_IDX_CNT, 0); `CHK("clr_a", 1'b1, r < 10)
        end_sim();
    end
endmodule
